// ===== common/qdac_pkg.sv
package qdac_pkg;

   // ----------------------------------------------------------------
   // frame layout
   // ----------------------------------------------------------------
   localparam int FRAME_BITS = 32;
   localparam int CODE_W = 16;
   localparam int NUM_CH = 4;
   localparam int CMD_LSB = 24;
   localparam int ADDR_LSB = 20;
   localparam int CODE_LSB = 4;

   // ----------------------------------------------------------------
   // commands, codes and reset values
   // ----------------------------------------------------------------
   localparam logic [3:0] CMD_WRITE = 4'h0;
   localparam logic [3:0] CMD_UPDATE = 4'h1;
   localparam logic [3:0] CMD_CLRSEL = 4'h5;
   localparam logic [3:0] ADDR_ALL = 4'hf;
   localparam logic [15:0] CODE_ZERO = 16'h0000;
   localparam logic [15:0] CODE_MID = 16'h8000;
   localparam logic [15:0] CODE_FULL = 16'hffff;
   localparam logic [1:0] CLRSEL_ZERO = 2'h0;
   localparam logic [1:0] CLRSEL_MID = 2'h1;
   localparam logic [1:0] CLRSEL_FULL = 2'h2;
   localparam logic [1:0] CLRSEL_RST = CLRSEL_ZERO;
   localparam logic [5:0] BITCNT_RST = 6'h00;
   localparam logic [1:0] INIT_WAIT = 2'h3;

   typedef enum logic [1:0] {
      ST_INIT = 2'b00,
      ST_RUN = 2'b01,
      ST_CLEAR = 2'b11
   } qdac_state_t;

endpackage : qdac_pkg

// ===== design/qdac_sync.sv
`timescale 1ns/1ps
module qdac_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic clk, // system clock
   input wire logic rst_n, // async reset
   input wire logic [W-1:0] d, // foreign levels
   output logic [W-1:0] q // synchronised levels
);

   logic [W-1:0] meta_q;

   // first stage is read by the second stage only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= RST;
         q <= RST;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end

endmodule : qdac_sync

// ===== design/qdac_link.sv
`timescale 1ns/1ps
module qdac_link
   import qdac_pkg::*;
(
   input wire logic sclk, // shift clock from host
   input wire logic rst_n, // async reset
   input wire logic sync_n, // frame select, active low
   input wire logic din, // serial data
   output logic [FRAME_BITS-1:0] word, // last complete frame
   output logic done_tgl // flips per complete frame
);

   localparam logic [5:0] FULL = 6'(FRAME_BITS);
   localparam logic [5:0] LAST = 6'(FRAME_BITS - 1);

   logic [5:0] cnt_q;
   logic [FRAME_BITS-1:0] sh_q;
   wire link_clr = sync_n | ~rst_n;
   wire take = !sync_n && (cnt_q != FULL);
   wire last = take && (cnt_q == LAST);

   // a raised frame select wipes the count at once, so a partial frame
   // never reaches the last bit even if the clock stops
   always_ff @(negedge sclk or posedge link_clr) begin
      if (link_clr) begin
         cnt_q <= BITCNT_RST;
      end else if (take) begin
         cnt_q <= cnt_q + 6'h01;
      end
   end

   always_ff @(negedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         sh_q <= '0;
      end else if (take) begin
         sh_q <= {sh_q[FRAME_BITS-2:0], din};
      end
   end

   always_ff @(negedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         word <= '0;
         done_tgl <= 1'b0;
      end else if (last) begin
         word <= {sh_q[FRAME_BITS-2:0], din};
         done_tgl <= ~done_tgl;
      end
   end

endmodule : qdac_link

// ===== design/qdac_top.sv
`timescale 1ns/1ps
module qdac_top
   import qdac_pkg::*;
(
   input wire logic clk, // system clock
   input wire logic rst_n, // async reset
   input wire logic sclk, // shift clock
   input wire logic sync_n, // frame select
   input wire logic din, // serial data
   input wire logic output_load_strobe_n, // load strobe
   input wire logic async_clear_n, // clear input
   input wire logic por_midscale, // power-up level
   output wire logic [63:0] dac_code, // output regs
   output wire logic [63:0] input_code, // input regs
   output logic [1:0] clear_sel // clear code
);

   // ----------------------------------------------------------------
   // link domain
   // ----------------------------------------------------------------
   logic [FRAME_BITS-1:0] link_word;
   logic link_tgl;

   qdac_link u_link (
      .sclk(sclk),
      .rst_n(rst_n),
      .sync_n(sync_n),
      .din(din),
      .word(link_word),
      .done_tgl(link_tgl)
   );

   // ----------------------------------------------------------------
   // pin edge capture
   // ----------------------------------------------------------------
   // the strobe and clear pulses may be shorter than a clk period,
   // so each falling edge flips a toggle on the pin itself
   logic clear_tgl_q;
   logic strobe_tgl_q;

   always_ff @(negedge async_clear_n or negedge rst_n) begin
      if (!rst_n) begin
         clear_tgl_q <= 1'b0;
      end else begin
         clear_tgl_q <= ~clear_tgl_q;
      end
   end

   always_ff @(negedge output_load_strobe_n or negedge rst_n) begin
      if (!rst_n) begin
         strobe_tgl_q <= 1'b0;
      end else begin
         strobe_tgl_q <= ~strobe_tgl_q;
      end
   end

   // ----------------------------------------------------------------
   // synchronisers
   // ----------------------------------------------------------------
   logic [5:0] pin_s;

   // levels reset to the idle pin state, so a released clear reads high
   qdac_sync #(
      .W(6),
      .RST(6'h38)
   ) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d({async_clear_n, output_load_strobe_n, por_midscale,
          clear_tgl_q, strobe_tgl_q, link_tgl}),
      .q(pin_s)
   );

   wire clear_lvl = pin_s[5];
   wire strobe_lvl = pin_s[4];
   wire por_lvl = pin_s[3];

   logic [2:0] tgl_prev_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tgl_prev_q <= 3'h0;
      end else begin
         tgl_prev_q <= pin_s[2:0];
      end
   end

   wire clear_ev = pin_s[2] ^ tgl_prev_q[2];
   wire strobe_ev = pin_s[1] ^ tgl_prev_q[1];
   wire frame_ev = pin_s[0] ^ tgl_prev_q[0];

   // ----------------------------------------------------------------
   // control state
   // ----------------------------------------------------------------
   qdac_state_t state_q;
   qdac_state_t state_d;
   logic [1:0] init_cnt_q;

   wire init_done = (state_q == ST_INIT) && (init_cnt_q == INIT_WAIT);
   wire live = (state_q != ST_INIT);
   wire clear_do = live && clear_ev;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_INIT: begin
            if (init_done) begin
               state_d = ST_RUN;
            end
         end
         ST_RUN: begin
            if (clear_ev) begin
               state_d = ST_CLEAR;
            end
         end
         ST_CLEAR: begin
            if (clear_lvl && !clear_ev) begin
               state_d = ST_RUN;
            end
         end
         default: begin
            state_d = ST_INIT;
         end
      endcase
   end

   // the level select is sampled only once it has passed the
   // synchroniser, well after reset has been released
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_INIT;
         init_cnt_q <= 2'h0;
      end else begin
         state_q <= state_d;
         if (!init_done) begin
            init_cnt_q <= init_cnt_q + 2'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // frame decode
   // ----------------------------------------------------------------
   // the link word is quiet for many link bits after its toggle,
   // so reading it on the synchronised toggle edge is safe
   wire [3:0] cmd = link_word[CMD_LSB +: 4];
   wire [3:0] addr = link_word[ADDR_LSB +: 4];
   wire [CODE_W-1:0] code = link_word[CODE_LSB +: CODE_W];
   wire frame_ok = frame_ev && live;
   wire clrsel_wr = frame_ok && (cmd == CMD_CLRSEL);

   // a strobe edge while clear is low, or caught with a clear, is lost
   wire strobe_ok = strobe_ev && clear_lvl && !clear_do
      && (state_q == ST_RUN);
   wire strobe_low = !strobe_lvl;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clear_sel <= CLRSEL_RST;
      end else if (clrsel_wr) begin
         clear_sel <= code[1:0];
      end
   end

   // ----------------------------------------------------------------
   // load value
   // ----------------------------------------------------------------
   wire [CODE_W-1:0] por_val = por_lvl ? CODE_MID : CODE_ZERO;
   wire [CODE_W-1:0] clear_val =
      (clear_sel == CLRSEL_MID) ? CODE_MID :
      (clear_sel == CLRSEL_FULL) ? CODE_FULL : CODE_ZERO;
   wire load_all = init_done || clear_do;
   wire [CODE_W-1:0] load_val = init_done ? por_val : clear_val;

   // ----------------------------------------------------------------
   // channel registers
   // ----------------------------------------------------------------
   for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      logic [CODE_W-1:0] in_q;
      logic [CODE_W-1:0] dac_q;
      wire sel = frame_ok && ((addr == ADDR_ALL) || (addr == 4'(i)));
      wire wr = sel && (cmd == CMD_WRITE);
      wire up = sel && (cmd == CMD_UPDATE);

      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            in_q <= CODE_ZERO;
            dac_q <= CODE_ZERO;
         end else if (load_all) begin
            in_q <= load_val;
            dac_q <= load_val;
         end else begin
            if (wr) begin
               in_q <= code;
            end
            if (wr && strobe_low) begin
               dac_q <= code;
            end else if (up) begin
               dac_q <= in_q;
            end else if (strobe_ok) begin
               dac_q <= in_q;
            end
         end
      end

      assign input_code[i*CODE_W +: CODE_W] = in_q;
      assign dac_code[i*CODE_W +: CODE_W] = dac_q;
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   wire quiet = !clear_do && !frame_ok;

   init_level_a: assert property (
      init_done |=> (dac_code == {4{$past(por_val)}})
         && (input_code == dac_code))
      else $error("power-up level not loaded");

   clear_load_a: assert property (
      clear_do |=> (input_code == {4{$past(clear_val)}})
         && (dac_code == input_code))
      else $error("clear code not loaded");

   clrsel_reset_a: assert property (
      (state_q == ST_INIT) |-> (clear_sel == CLRSEL_ZERO)
         && (clear_val == CODE_ZERO))
      else $error("clear code not zero after reset");

   strobe_ignore_a: assert property (
      (strobe_ev && !clear_lvl && quiet) |=> $stable(dac_code))
      else $error("strobe edge acted while clear low");

   strobe_xfer_a: assert property (
      (strobe_ok && quiet) |=> (dac_code == $past(input_code)))
      else $error("strobe edge did not copy all channels");

   write_hold_a: assert property (
      (frame_ok && !clear_do && !strobe_ev && strobe_lvl
         && (cmd == CMD_WRITE)) |=> $stable(dac_code))
      else $error("output moved with strobe high");

   write_input_a: assert property (
      (g_ch[0].wr && !load_all) |=>
         (input_code[15:0] == $past(code)))
      else $error("write missed input register");

   write_now_a: assert property (
      (g_ch[0].wr && !load_all && strobe_low) |=>
         (dac_code[15:0] == $past(code)) ##1 ($stable(dac_code[15:0])
         || $past(strobe_ev || clear_ev || frame_ev)))
      else $error("write with strobe low missed output");

   update_cmd_a: assert property (
      (g_ch[3].up && !load_all) |=>
         (dac_code[63:48] == $past(input_code[63:48])))
      else $error("copy command missed output register");

   clear_state_a: assert property (
      (clear_do && !clear_lvl) |=> (state_q == ST_CLEAR) [*2]
         or clear_lvl)
      else $error("clear state left while pin low");

   // ----------------------------------------------------------------
   // quiet-cycle and decode checks
   // ----------------------------------------------------------------
   // registers may only move on a decoded event; anything else would
   // be a leak from the link or pin logic
   wire no_ev = !frame_ok && !strobe_ok && !load_all;

   input_quiet_a: assert property (
      (!frame_ok && !load_all) |=> $stable(input_code))
      else $error("input register moved without a frame");

   output_quiet_a: assert property (
      no_ev |=> $stable(dac_code))
      else $error("output register moved without an event");

   init_zero_a: assert property (
      (state_q == ST_INIT) |-> (dac_code == '0) && (input_code == '0))
      else $error("registers not zero during start-up");

   clrsel_write_a: assert property (
      clrsel_wr |=> (clear_sel == $past(code[1:0])))
      else $error("clear code select not written");

   clear_full_a: assert property (
      (clear_do && (clear_sel == CLRSEL_FULL)) |=>
         (dac_code == {4{CODE_FULL}}))
      else $error("full-scale clear not loaded");

   clear_mid_a: assert property (
      (clear_do && (clear_sel == CLRSEL_MID)) |=>
         (dac_code == {4{CODE_MID}}))
      else $error("midscale clear not loaded");

   clear_zero_a: assert property (
      (clear_do && (clear_sel != CLRSEL_MID)
         && (clear_sel != CLRSEL_FULL)) |=> (dac_code == '0))
      else $error("zero clear not loaded");

   clear_enter_a: assert property (
      clear_do |=> (state_q == ST_CLEAR))
      else $error("clear did not enter clear state");

   clear_exit_a: assert property (
      ((state_q == ST_CLEAR) && clear_lvl && !clear_ev) |=>
         (state_q == ST_RUN))
      else $error("clear state not left after pin release");

   strobe_in_clear_a: assert property (
      (strobe_ev && (state_q == ST_CLEAR) && quiet) |=> $stable(dac_code))
      else $error("strobe edge acted in clear state");

   other_ch_a: assert property (
      (frame_ok && !g_ch[2].sel && !load_all) |=>
         $stable(input_code[47:32]))
      else $error("frame reached an unaddressed channel");

   all_write_a: assert property (
      (frame_ok && (addr == ADDR_ALL) && (cmd == CMD_WRITE) && !load_all)
         |=> (input_code == {4{$past(code)}}))
      else $error("broadcast write missed a channel");

   update_all_a: assert property (
      (frame_ok && (addr == ADDR_ALL) && (cmd == CMD_UPDATE) && !load_all)
         |=> (dac_code == $past(input_code)))
      else $error("broadcast copy missed a channel");

   write_keep_a: assert property (
      (g_ch[3].wr && !load_all && !strobe_ok && strobe_lvl) |=>
         $stable(dac_code[63:48]))
      else $error("write with strobe high moved the output");

   cmd_other_a: assert property (
      (frame_ok && (cmd != CMD_WRITE) && (cmd != CMD_UPDATE)
         && !load_all && !strobe_ok) |=>
         ($stable(input_code) && $stable(dac_code)))
      else $error("unknown command changed a register");

endmodule : qdac_top

// ===== verif/qdac_host.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// host side of the serial link
// ----------------------------------------------------------------
module qdac_host (
   output logic sclk, // shift clock, idle high
   output logic sync_n, // frame select
   output logic din // serial data
);
   initial begin
      sclk = 1'b1;
      sync_n = 1'b1;
      din = 1'b0;
   end

   // sends the first n bits of w, msb first; n below 32 aborts the frame
   // the clock only runs inside a frame, 12 ns period
   task automatic send(input logic [31:0] w, input int n);
      sync_n = 1'b0;
      for (int i = 31; i > 31 - n; i--) begin
         #3 din = w[i];
         #3 sclk = 1'b0;
         #6 sclk = 1'b1;
      end
      #3 sync_n = 1'b1;
      // a released line must not keep showing the last bit
      din = ~din;
   endtask : send
endmodule : qdac_host

// ===== verif/tb_quad_dac_serial_load_control.sv
`timescale 1ns/1ps
module tb_quad_dac_serial_load_control;
   import qdac_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic strobe_n = 1'b1;
   logic clear_n = 1'b1;
   logic por = 1'b0;
   wire logic sclk;
   wire logic sync_n;
   wire logic din;
   wire logic [63:0] dac_code;
   wire logic [63:0] input_code;
   wire logic [1:0] clear_sel;
   int bad_count = 0;
   int num_checks = 0;
   int seed = 32'ha1784f61;
   int in_m[4];
   int out_m[4];
   int sel_m;

   always #20 clk = ~clk;

   qdac_host host (.sclk(sclk), .sync_n(sync_n), .din(din));
   qdac_top DUT (.clk(clk), .rst_n(rst_n), .sclk(sclk), .sync_n(sync_n),
      .din(din), .output_load_strobe_n(strobe_n), .async_clear_n(clear_n),
      .por_midscale(por), .dac_code(dac_code), .input_code(input_code),
      .clear_sel(clear_sel));

   // ----------------------------------------------------------------
   // comparison and report
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : print_verdict

   // waits out the crossing latency, then compares every register
   task automatic check_all(input string t);
      repeat (8) @(negedge clk);
      for (int c = 0; c < 4; c++) begin
         check("input reg", input_code[16*c +: 16], 16'(in_m[c]));
         check("dac reg", dac_code[16*c +: 16], 16'(out_m[c]));
      end
      check("clear sel", {14'h0, clear_sel}, 16'(sel_m));
      $display("test %s done", t);
   endtask : check_all

   // ----------------------------------------------------------------
   // stimulus with model updates
   // ----------------------------------------------------------------
   task automatic frame(input logic [3:0] cmd, input logic [3:0] ch,
                        input logic [15:0] v, input int n);
      host.send({4'h0, cmd, ch, v, 4'h0}, n);
      for (int c = 0; c < 4 && n == 32; c++) begin
         if (ch == ADDR_ALL || ch == 4'(c)) begin
            if (cmd == CMD_WRITE)
               in_m[c] = v;
            if ((cmd == CMD_WRITE && !strobe_n) || cmd == CMD_UPDATE)
               out_m[c] = in_m[c];
         end
      end
      if (n == 32 && cmd == CMD_CLRSEL)
         // the select holds the raw code; 3 only acts as zero on a clear
         sel_m = v[1:0];
      check_all("frame");
   endtask : frame

   task automatic set_strobe(input logic v);
      @(negedge clk) strobe_n <= v;
      // a falling strobe copies every channel unless clear is held
      for (int c = 0; c < 4 && !v && clear_n; c++)
         out_m[c] = in_m[c];
      check_all("strobe");
   endtask : set_strobe

   task automatic do_reset(input logic p);
      @(negedge clk);
      rst_n <= 1'b0;
      por <= p;
      repeat (20) @(negedge clk);
      rst_n <= 1'b1;
      for (int c = 0; c < 4; c++) begin
         in_m[c] = p ? CODE_MID : CODE_ZERO;
         out_m[c] = in_m[c];
      end
      sel_m = 0;
      check_all("reset");
   endtask : do_reset

   task automatic clear(input int s);
      logic [15:0] code;
      code = (s == 1) ? CODE_MID : (s == 2) ? CODE_FULL : CODE_ZERO;
      frame(CMD_CLRSEL, 4'h0, 16'(s), 32);
      @(negedge clk) clear_n <= 1'b0;
      for (int c = 0; c < 4; c++) begin
         in_m[c] = code;
         out_m[c] = code;
      end
      check_all("clear");
      // a held-low clear must not keep wiping later writes
      frame(CMD_WRITE, 4'h2, 16'($random(seed)), 32);
      set_strobe(1'b0);
      set_strobe(1'b1);
      @(negedge clk) clear_n <= 1'b1;
   endtask : clear

   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      for (int p = 0; p < 2; p++)
         do_reset(p[0]);
      for (int c = 0; c < 4; c++)
         frame(CMD_WRITE, 4'(c), 16'($random(seed)), 32);
      set_strobe(1'b0);
      frame(CMD_WRITE, 4'h1, 16'($random(seed)), 32);
      frame(CMD_WRITE, ADDR_ALL, 16'($random(seed)), 32);
      set_strobe(1'b1);
      frame(CMD_WRITE, 4'h3, 16'($random(seed)), 31);
      frame(CMD_WRITE, 4'h3, 16'($random(seed)), 32);
      frame(CMD_UPDATE, 4'h3, 16'h0000, 32);
      frame(CMD_WRITE, ADDR_ALL, 16'($random(seed)), 32);
      frame(CMD_UPDATE, ADDR_ALL, 16'h0000, 32);
      for (int s = 0; s < 4; s++)
         clear(s);
      print_verdict();
   end

   initial begin
      repeat (50000) @(posedge clk);
      bad_count++;
      $display("timeout waiting for the main sequence");
      print_verdict();
   end
endmodule : tb_quad_dac_serial_load_control
